// ### hdl/srpc_params.svh
// Timing and width constants for the refresh and power control link
`ifndef SRPC_PARAMS_SVH
`define SRPC_PARAMS_SVH
`define SRPC_CLK_PERIOD_NS 100
`define SRPC_TRC_NS 60
`define SRPC_TRP_NS 18
`define SRPC_TIS_NS 2
`define SRPC_TREFI_NS 15600
`define SRPC_REFRESH_WINDOW_MS 64
`define SRPC_REFRESH_ROWS 4096
`define SRPC_ROW_BITS 12
`define SRPC_TRC_CYC ((`SRPC_TRC_NS + `SRPC_CLK_PERIOD_NS - 1) / `SRPC_CLK_PERIOD_NS)
`define SRPC_TRP_CYC ((`SRPC_TRP_NS + `SRPC_CLK_PERIOD_NS - 1) / `SRPC_CLK_PERIOD_NS)
`define SRPC_XSR_CYC \
   ((`SRPC_TRC_NS + `SRPC_TIS_NS + `SRPC_CLK_PERIOD_NS - 1) / `SRPC_CLK_PERIOD_NS)
`define SRPC_PDE_CYC \
   ((`SRPC_TIS_NS + `SRPC_CLK_PERIOD_NS + `SRPC_CLK_PERIOD_NS - 1) / `SRPC_CLK_PERIOD_NS)
`define SRPC_TREFI_CYC (`SRPC_TREFI_NS / `SRPC_CLK_PERIOD_NS)
`define SRPC_SELF_REF_CYC 16
`endif

// ### hdl/srpc_pkg.sv
// Types shared by the refresh and power control ends
package srpc_pkg;
   typedef enum logic [1:0] {
      SRPC_MODE_ACTIVE,
      SRPC_MODE_SUSPEND,
      SRPC_MODE_LOW_POWER,
      SRPC_MODE_RETENTION
   } srpc_mode_type;
endpackage : srpc_pkg

// ### hdl/srpc_link_if.sv
// Command pins between memory controller and memory device
interface srpc_link_if;
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic [11:0] addr;
   logic dqm;
   logic [15:0] dq_to_mem;
   logic [15:0] dq_from_mem;
   logic dq_mem_oe;
   modport controller (output cke, cs_n, ras_n, cas_n, we_n, addr, dqm, dq_to_mem,
      input dq_from_mem, dq_mem_oe);
   modport device (input cke, cs_n, ras_n, cas_n, we_n, addr, dqm, dq_to_mem,
      output dq_from_mem, dq_mem_oe);
endinterface : srpc_link_if

// ### hdl/srpc_row_counter.sv
// Wrapping refresh row counter
module srpc_row_counter #(
   parameter int ROW_BITS = 12
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic step,
   output logic [ROW_BITS-1:0] row
);
   always_ff @(posedge clk) begin
      if (!resetn) begin
         row <= '0;
      end else if (step) begin
         row <= row + 1'b1;
      end
   end
endmodule : srpc_row_counter

// ### hdl/srpc_device.sv
// Memory device end: command qualification, refresh, suspend and low power idle
// Functional notes
// - Deselect ignores all command and address inputs
// - Strobes low low high with gate high
// - Row counter advances on each refresh
// - Controller issues 4096 refreshes per 64ms
// - Refresh only when idle and out of power-down
// - Only no-operations until row cycle ends
// - Precharge time between successive refreshes
// - Refresh pattern with gate low enters retention
// - Retention refreshes rows internally, no limit
// - Restart clock, then raise gate to exit
// - Only no-ops for retention exit wait
// - Refresh burst before and after retention; controller sends no burst, only a refresh that is already due
// - Gate low in burst freezes state next cycle
// - Gate low while idle enters low power
// - Suspend or low power at most 64ms
// - Internal clock restarts cycle after gate high
// - Buffers re-enabled on low power exit
// - Mask pin masks writes, disables reads
// - Refresh interval at most 15.6us average
// - Retention exit wait is row cycle plus setup
// - Low power exit setup is setup plus period
`include "srpc_params.svh"
module srpc_device import srpc_pkg::*; #(
   parameter int ROW_BITS = `SRPC_ROW_BITS,
   parameter int SELF_REF_CYC = `SRPC_SELF_REF_CYC
) (
   input wire logic clk,
   input wire logic resetn,
   srpc_link_if.device link,
   input wire logic bank_busy,
   input wire logic read_cycle,
   input wire logic write_cycle,
   input wire logic [15:0] read_data,
   output logic [ROW_BITS-1:0] refresh_row,
   output logic refresh_pulse,
   output logic [1:0] mode,
   output logic buffers_on,
   output logic write_accept,
   output logic [15:0] write_data
);
   srpc_mode_type state;
   logic cke_q1;
   logic cke_s;
   logic cs_q1, ras_q1, cas_q1, we_q1, dqm_q1;
   logic cs_s, ras_s, cas_s, we_s, dqm_s;
   logic [15:0] dq_q1;
   logic [15:0] dq_s;
   logic cke_prev;
   logic refresh_pattern;
   logic do_refresh;
   logic internal_tick;
   logic step;
   logic [7:0] self_cnt;
   logic dq_oe;
   logic [15:0] dq_out;

   // ****************
   // Input synchronisers
   // ****************
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cke_q1 <= 1'b0;
         cke_s <= 1'b0;
         cs_q1 <= 1'b1;
         cs_s <= 1'b1;
         ras_q1 <= 1'b1;
         ras_s <= 1'b1;
         cas_q1 <= 1'b1;
         cas_s <= 1'b1;
         we_q1 <= 1'b1;
         we_s <= 1'b1;
         dqm_q1 <= 1'b1;
         dqm_s <= 1'b1;
         dq_q1 <= 16'h0000;
         dq_s <= 16'h0000;
      end else begin
         cke_q1 <= link.cke;
         cke_s <= cke_q1;
         cs_q1 <= link.cs_n;
         cs_s <= cs_q1;
         ras_q1 <= link.ras_n;
         ras_s <= ras_q1;
         cas_q1 <= link.cas_n;
         cas_s <= cas_q1;
         we_q1 <= link.we_n;
         we_s <= we_q1;
         dqm_q1 <= link.dqm;
         dqm_s <= dqm_q1;
         dq_q1 <= link.dq_to_mem;
         dq_s <= dq_q1;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cke_prev <= 1'b0;
      end else begin
         cke_prev <= cke_s;
      end
   end

   // ****************
   // Command decode
   // ****************
   // Address is never examined: refresh rows come from the internal counter
   assign refresh_pattern = !cs_s && !ras_s && !cas_s && we_s;
   assign do_refresh = refresh_pattern && cke_s && cke_prev && state == SRPC_MODE_ACTIVE;

   // ****************
   // Mode control
   // ****************
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state <= SRPC_MODE_ACTIVE;
      end else begin
         case (state)
            SRPC_MODE_ACTIVE: begin
               if (cke_prev && !cke_s) begin
                  if (refresh_pattern) begin
                     state <= SRPC_MODE_RETENTION;
                  end else if (bank_busy) begin
                     state <= SRPC_MODE_SUSPEND;
                  end else begin
                     state <= SRPC_MODE_LOW_POWER;
                  end
               end
            end
            SRPC_MODE_SUSPEND: begin
               if (cke_s) begin
                  state <= SRPC_MODE_ACTIVE;
               end
            end
            SRPC_MODE_LOW_POWER: begin
               if (cke_s) begin
                  state <= SRPC_MODE_ACTIVE;
               end
            end
            SRPC_MODE_RETENTION: begin
               if (cke_s) begin
                  state <= SRPC_MODE_ACTIVE;
               end
            end
            default: begin
               state <= SRPC_MODE_ACTIVE;
            end
         endcase
      end
   end

   // ****************
   // Internal refresh timer for retention
   // ****************
   always_ff @(posedge clk) begin
      if (!resetn) begin
         self_cnt <= 8'h00;
      end else if (state == SRPC_MODE_RETENTION) begin
         if (self_cnt == 8'(SELF_REF_CYC - 1)) begin
            self_cnt <= 8'h00;
         end else begin
            self_cnt <= self_cnt + 8'h01;
         end
      end else begin
         self_cnt <= 8'h00;
      end
   end

   assign internal_tick = state == SRPC_MODE_RETENTION && self_cnt == 8'(SELF_REF_CYC - 1);
   assign step = do_refresh || internal_tick;

   srpc_row_counter #(.ROW_BITS(ROW_BITS)) u_rows (
      .clk(clk),
      .resetn(resetn),
      .step(step),
      .row(refresh_row)
   );

   // ****************
   // Outputs and data path
   // ****************
   always_ff @(posedge clk) begin
      if (!resetn) begin
         refresh_pulse <= 1'b0;
         mode <= 2'h0;
         buffers_on <= 1'b0;
      end else begin
         refresh_pulse <= step;
         mode <= state;
         buffers_on <= state == SRPC_MODE_ACTIVE || state == SRPC_MODE_SUSPEND;
      end
   end

   // Suspended state keeps write data frozen
   always_ff @(posedge clk) begin
      if (!resetn) begin
         write_accept <= 1'b0;
         write_data <= 16'h0000;
      end else begin
         write_accept <= write_cycle && !dqm_s && state == SRPC_MODE_ACTIVE && cke_s;
         if (write_cycle && !dqm_s && state == SRPC_MODE_ACTIVE && cke_s) begin
            write_data <= dq_s;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         dq_oe <= 1'b0;
         dq_out <= 16'h0000;
      end else begin
         dq_oe <= read_cycle && !dqm_s && state == SRPC_MODE_ACTIVE;
         dq_out <= read_data;
      end
   end

   assign link.dq_from_mem = dq_out;
   assign link.dq_mem_oe = dq_oe;
endmodule : srpc_device

// ### hdl/srpc_controller.sv
// Memory controller end: refresh scheduling and power mode sequencing
`include "srpc_params.svh"
module srpc_controller import srpc_pkg::*; #(
   parameter int TREFI_CYC = `SRPC_TREFI_CYC
) (
   input wire logic clk,
   input wire logic resetn,
   srpc_link_if.controller link,
   input wire logic enter_retention,
   input wire logic enter_low_power,
   input wire logic wake,
   output logic busy,
   output logic [1:0] mode,
   output logic refresh_issued
);
   typedef enum logic [2:0] {
      CS_IDLE, CS_REF_WAIT, CS_PRE_WAIT, CS_RET, CS_LOW, CS_EXIT_WAIT
   } srpc_ctl_type;
   srpc_ctl_type st;
   logic [11:0] wait_cnt;
   logic [11:0] ival_cnt;
   logic refresh_due;

   // Periodic interval timer
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ival_cnt <= 12'h000;
      end else if (st == CS_IDLE && refresh_due) begin
         ival_cnt <= 12'h000;
      end else if (ival_cnt != 12'(TREFI_CYC - 1)) begin
         ival_cnt <= ival_cnt + 12'h001;
      end
   end
   assign refresh_due = ival_cnt == 12'(TREFI_CYC - 1);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         st <= CS_IDLE;
         wait_cnt <= 12'h000;
         link.cke <= 1'b0;
         link.cs_n <= 1'b1;
         link.ras_n <= 1'b1;
         link.cas_n <= 1'b1;
         link.we_n <= 1'b1;
         link.addr <= 12'h000;
         link.dqm <= 1'b1;
         link.dq_to_mem <= 16'h0000;
         busy <= 1'b1;
         mode <= 2'h0;
         refresh_issued <= 1'b0;
      end else begin
         link.cs_n <= 1'b1;
         link.ras_n <= 1'b1;
         link.cas_n <= 1'b1;
         link.we_n <= 1'b1;
         refresh_issued <= 1'b0;
         busy <= st != CS_IDLE;
         case (st)
            CS_IDLE: begin
               link.cke <= 1'b1;
               mode <= SRPC_MODE_ACTIVE;
               if (link.cke && (refresh_due || enter_retention)) begin
                  link.cs_n <= 1'b0;
                  link.ras_n <= 1'b0;
                  link.cas_n <= 1'b0;
                  refresh_issued <= 1'b1;
                  if (enter_retention && !refresh_due) begin
                     link.cke <= 1'b0;
                     st <= CS_RET;
                  end else begin
                     wait_cnt <= 12'(`SRPC_TRC_CYC);
                     st <= CS_REF_WAIT;
                  end
               end else if (enter_low_power) begin
                  link.cke <= 1'b0;
                  st <= CS_LOW;
               end
            end
            CS_REF_WAIT: begin
               if (wait_cnt <= 12'h001) begin
                  wait_cnt <= 12'(`SRPC_TRP_CYC);
                  st <= CS_PRE_WAIT;
               end else begin
                  wait_cnt <= wait_cnt - 12'h001;
               end
            end
            CS_PRE_WAIT: begin
               if (wait_cnt <= 12'h001) begin
                  st <= CS_IDLE;
               end else begin
                  wait_cnt <= wait_cnt - 12'h001;
               end
            end
            CS_RET: begin
               link.cke <= 1'b0;
               mode <= SRPC_MODE_RETENTION;
               if (wake) begin
                  link.cke <= 1'b1;
                  wait_cnt <= 12'(`SRPC_XSR_CYC);
                  st <= CS_EXIT_WAIT;
               end
            end
            CS_LOW: begin
               link.cke <= 1'b0;
               mode <= SRPC_MODE_LOW_POWER;
               if (wake || refresh_due) begin
                  link.cke <= 1'b1;
                  wait_cnt <= 12'(`SRPC_PDE_CYC);
                  st <= CS_EXIT_WAIT;
               end
            end
            CS_EXIT_WAIT: begin
               link.cke <= 1'b1;
               if (wait_cnt <= 12'h001) begin
                  st <= CS_IDLE;
               end else begin
                  wait_cnt <= wait_cnt - 12'h001;
               end
            end
            default: begin
               st <= CS_IDLE;
            end
         endcase
      end
   end
endmodule : srpc_controller

// ### verification/srpc_link_asserts.sv
// Checker on the command pins between the controller and device ends
module srpc_link_asserts #(
   parameter int TREFI_CYC = 156
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic dqm
);
   // ****************************************
   // Command decode helpers
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   logic pat;
   logic quiet;
   logic [15:0] gap;
   assign pat = !cs_n && !ras_n && !cas_n && we_n;
   assign quiet = cs_n || (ras_n && cas_n && we_n);
   // Cycles since the last refresh while the gate is high
   always_ff @(posedge clk) begin
      if (!resetn || pat || !cke) begin
         gap <= 16'h0000;
      end else begin
         gap <= gap + 16'h0001;
      end
   end
   sequence s_refresh;
      pat && cke;
   endsequence
   sequence s_enter;
      pat && !cke && $past(cke);
   endsequence
   sequence s_exit;
      $rose(cke);
   endsequence
   // ****************************************
   // Assertions
   // ****************************************
   ref_prev_gate_a: assert property (s_refresh |-> $past(cke))
      else $error("refresh issued while gate was low");
   ref_quiet_a: assert property (s_refresh |=> quiet)
      else $error("command during refresh row cycle");
   ref_spacing_a: assert property (s_refresh |=> !pat [*2])
      else $error("refreshes too close together");
   retain_gate_a: assert property (s_enter |=> !cke)
      else $error("gate released right after retention entry");
   exit_quiet_a: assert property (s_exit |-> quiet)
      else $error("command on gate exit cycle");
   exit_wait_a: assert property (s_exit |=> quiet)
      else $error("command inside exit wait");
   ref_interval_a: assert property (gap < 16'(TREFI_CYC + 8))
      else $error("refresh interval too long");
   reset_idle_a: assert property (disable iff (1'b0) !resetn |=> !cke && cs_n && dqm)
      else $error("link not idle under reset");
endmodule : srpc_link_asserts

// ### verification/tb.sv
// Testbench joining the controller and device ends across the command link
module tb import srpc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TREFI = 20;
   localparam int SELF_REF = 16;
   logic clk, resetn, bank_busy, read_cycle, write_cycle;
   logic enter_retention, enter_low_power, wake;
   logic [15:0] read_data;
   logic [11:0] row, row_b, r;
   logic pulse, pulse_b, bufon, busy, issued;
   logic wacc;
   logic [15:0] wdata;
   logic [1:0] dmode, cmode;
   int n_errors = 0;
   int samples_checked = 0;
   int n, k, cnt;
   srpc_link_if link();
   srpc_link_if link_b();
   srpc_controller #(.TREFI_CYC(TREFI)) srpc_controller_inst (.clk(clk), .resetn(resetn),
      .link(link), .enter_retention(enter_retention), .enter_low_power(enter_low_power),
      .wake(wake), .busy(busy), .mode(cmode), .refresh_issued(issued));
   srpc_device #(.SELF_REF_CYC(SELF_REF)) srpc_device_inst (.clk(clk), .resetn(resetn),
      .link(link), .bank_busy(bank_busy), .read_cycle(read_cycle), .write_cycle(write_cycle),
      .read_data(read_data), .refresh_row(row), .refresh_pulse(pulse), .mode(dmode),
      .buffers_on(bufon), .write_accept(), .write_data());
   // Second device end whose pins the bench drives directly
   srpc_device #(.SELF_REF_CYC(SELF_REF)) srpc_device_inst_b (.clk(clk), .resetn(resetn),
      .link(link_b), .bank_busy(bank_busy), .read_cycle(read_cycle),
      .write_cycle(write_cycle), .read_data(read_data), .refresh_row(row_b),
      .refresh_pulse(pulse_b), .mode(), .buffers_on(), .write_accept(wacc), .write_data(wdata));
   srpc_link_asserts #(.TREFI_CYC(TREFI)) srpc_link_asserts_inst (.clk(clk),
      .resetn(resetn), .cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n),
      .cas_n(link.cas_n), .we_n(link.we_n), .dqm(link.dqm));
   // ****************************************
   // Tasks
   // ****************************************
   task automatic check(string what, logic [15:0] exp, logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
         n_errors++;
      end
   endtask : check
   task automatic wait_mode(logic [1:0] exp);
      for (int i = 0; i < 300 && dmode !== exp; i++) @(negedge clk);
      check("device mode", 12'(exp), 12'(dmode));
   endtask : wait_mode
   task automatic wait_pulse();
      n = 0;
      cnt = 0;
      do begin
         @(negedge clk);
         n++;
         cnt += int'(issued === 1'b1);
      end while (pulse !== 1'b1 && n < 400);
   endtask : wait_pulse
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test
   // ****************************************
   // Clock, watchdog and tests
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      #(100 * 20000);
      n_errors++;
      stop_test();
   end
   initial begin
      {resetn, bank_busy, read_cycle, write_cycle, enter_retention} = 5'h00;
      {enter_low_power, wake, read_data} = 18'h00000;
      {link_b.cke, link_b.cs_n, link_b.ras_n, link_b.cas_n, link_b.we_n} = 5'h1F;
      {link_b.addr, link_b.dqm, link_b.dq_to_mem} = 29'h0000000;
      repeat (12) @(posedge clk);
      @(negedge clk);
      check("gate in reset", 12'h000, 12'(link.cke));
      @(posedge clk) resetn <= 1'b1;
      repeat (2) @(posedge clk);
      for (k = 0; k < 2; k++) begin
         @(posedge clk);
         {link_b.cs_n, link_b.ras_n, link_b.cas_n, link_b.addr} <= {~k[0], 2'h0, 12'hFFF};
         @(posedge clk);
         {link_b.cs_n, link_b.ras_n, link_b.cas_n} <= 3'h7;
         cnt = 0;
         repeat (8) @(negedge clk) cnt += int'(pulse_b === 1'b1);
         check("refreshes seen", 12'(k), 12'(cnt));
      end
      check("second end row", 12'h001, row_b);
      // Mask pin gates write capture and read drive on the second end
      for (k = 0; k < 2; k++) begin
         @(posedge clk);
         {link_b.dqm, link_b.dq_to_mem} <= {k[0], 16'hA5C3};
         repeat (3) @(posedge clk);
         {write_cycle, read_cycle, read_data} <= {2'h3, 16'h3C5A};
         @(posedge clk);
         {write_cycle, read_cycle} <= 2'h0;
         @(negedge clk);
         check("write taken", 16'(!k[0]), 16'(wacc));
         check("write word", 16'hA5C3, wdata);
         check("read drive", 16'(!k[0]), 16'(link_b.dq_mem_oe));
         check("read word", 16'h3C5A, link_b.dq_from_mem);
      end
      wait_pulse();
      r = row;
      for (k = 0; k < 4; k++) begin
         wait_pulse();
         check("refresh row", r + 12'h001, row);
         check("interval kept", 12'h001, 12'(n <= TREFI + 4));
         check("refresh issued", 12'h001, 12'(cnt));
         r = row;
      end
      for (k = 0; k < 2; k++) begin
         @(posedge clk);
         {bank_busy, enter_low_power} <= {k[0], 1'b1};
         wait_mode(k[0] ? 2'(SRPC_MODE_SUSPEND) : 2'(SRPC_MODE_LOW_POWER));
         if (k == 0) begin
            check("buffers off", 12'h000, 12'(bufon));
            check("controller mode", 16'(SRPC_MODE_LOW_POWER), 16'(cmode));
            check("controller busy", 16'h0001, 16'(busy));
         end
         @(posedge clk);
         {enter_low_power, wake} <= 2'h1;
         wait_mode(2'(SRPC_MODE_ACTIVE));
         check("controller mode", 16'(SRPC_MODE_ACTIVE), 16'(cmode));
         check("buffers on", 12'h001, 12'(bufon));
         @(posedge clk) {bank_busy, wake} <= 2'h0;
      end
      @(posedge clk) enter_retention <= 1'b1;
      wait_mode(2'(SRPC_MODE_RETENTION));
      check("controller mode", 16'(SRPC_MODE_RETENTION), 16'(cmode));
      wait_pulse();
      r = row;
      wait_pulse();
      check("retention row", r + 12'h001, row);
      check("retention interval", 12'(SELF_REF), 12'(n));
      @(posedge clk) {enter_retention, wake} <= 2'h1;
      wait_mode(2'(SRPC_MODE_ACTIVE));
      check("controller mode", 16'(SRPC_MODE_ACTIVE), 16'(cmode));
      @(posedge clk) wake <= 1'b0;
      wait_pulse();
      check("refresh after exit", 12'h001, 12'(pulse));
      stop_test();
   end
endmodule : tb
